// ---- qsr_pkg.sv ----
// quad serial read controller: shared constants plus the serial clock divider
// assumes one system clock (clk_sys, 25 MHz) and an asynchronous active-high reset
`default_nettype none

package qsr_pkg;
  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int          CLK_PS          = 40000;
  localparam int          SCLK_MIN_PS     = 12500;
  localparam int          SCLK_MIN_CYC    = (SCLK_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int          WORD_MAX        = 128;
  localparam int          LEN_W           = 7;
  localparam int          CNT_W           = 12;
  localparam int          CMD_BITS        = 32;
  localparam logic [4:0]  CMD_LAST        = 5'h1f;
  localparam logic [1:0]  TAIL_PERIODS    = 2'h2;
  localparam logic [1:0]  LANE_SINGLE     = 2'h0;
  localparam logic [1:0]  LANE_DUAL       = 2'h1;
  localparam logic [1:0]  LANE_QUAD       = 2'h2;

  typedef enum logic [2:0] {QSR_IDLE, QSR_SEL, QSR_CMD, QSR_DATA, QSR_TAIL} qsr_state_t;
endpackage : qsr_pkg

// ------------------------------------------------------------------
// serial clock divider: period of factor+1 system cycles, minimum two
// ------------------------------------------------------------------
module qsr_clkdiv #(
  parameter int DIV_W = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] div,
  output logic                  rise_tk,
  output logic                  fall_tk
);
  logic [DIV_W:0] per;
  logic [DIV_W:0] hi_len;
  logic [DIV_W:0] lo_len;
  logic [DIV_W:0] cnt_r;

  // a factor of 0 or 1 cannot give a shorter period than two cycles
  always_comb begin
    per    = (div < DIV_W'(2)) ? (DIV_W+1)'(2) : {1'b0, div} + (DIV_W+1)'(1);
    hi_len = per >> 1;
    lo_len = per - hi_len;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (!run || cnt_r == per - (DIV_W+1)'(1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + (DIV_W+1)'(1);
    end
  end

  assign rise_tk = run && (cnt_r == lo_len - (DIV_W+1)'(1));
  assign fall_tk = run && (cnt_r == per - (DIV_W+1)'(1));
endmodule : qsr_clkdiv // qsr_clkdiv

`default_nettype wire

// ---- qsr_ctrl.sv ----
// quad serial read controller top: one memory-mapped request reads one frame of words
// assumes config ports are stable while busy and dq_i comes straight from the pads
`default_nettype none

module qsr_ctrl #(
  parameter int DIV_W = 8
) (
  input  wire logic                            clk_sys,
  input  wire logic                            rst,
  input  wire logic                            mm_req,
  input  wire logic [23:0]                     mm_addr,
  output logic                                 mm_ack,
  input  wire logic [7:0]                      cmd_opcode,
  input  wire logic [1:0]                      lane_mode,
  input  wire logic [qsr_pkg::LEN_W-1:0]       word_len,
  input  wire logic [qsr_pkg::CNT_W-1:0]       word_cnt,
  input  wire logic [1:0]                      select_to_clock_delay_field,
  input  wire logic [DIV_W-1:0]                serial_clock_divide_factor,
  input  wire logic                            word_irq_en,
  input  wire logic                            frame_irq_en,
  output logic                                 busy,
  output logic [qsr_pkg::WORD_MAX-1:0]         word_data,
  output logic                                 word_valid,
  output logic                                 frame_done,
  output logic                                 word_irq,
  output logic                                 frame_irq,
  output logic                                 sclk,
  output logic                                 cs_n,
  input  wire logic [3:0]                      dq_i,
  output logic [3:0]                           dq_o,
  output logic [3:0]                           dq_oe
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  qsr_pkg::qsr_state_t                 state_r;
  logic                                rise_tk;
  logic                                fall_tk;
  logic [3:0]                          dq_s1_r;
  logic [3:0]                          dq_s2_r;
  logic [1:0]                          per_r;
  logic [4:0]                          cmd_cnt_r;
  logic [31:0]                         cmd_sh_r;
  logic [1:0]                          mode_r;
  logic [qsr_pkg::LEN_W-1:0]           len_r;
  logic [qsr_pkg::CNT_W-1:0]           words_r;
  logic [7:0]                          col_r;
  logic [7:0]                          col_nxt;
  logic [qsr_pkg::WORD_MAX-1:0]        sh_r;
  logic [qsr_pkg::WORD_MAX-1:0]        sh_nxt;
  logic                                accept;
  logic                                smp;
  logic                                wdone;

  function automatic logic [7:0] bits_per_edge(input logic [1:0] m);
    if (m == qsr_pkg::LANE_SINGLE) begin
      return 8'h01;
    end else if (m == qsr_pkg::LANE_DUAL) begin
      return 8'h02;
    end else begin
      return 8'h04;
    end
  endfunction

  // ----------------------------------------------------------------
  // clocking and input synchroniser
  // ----------------------------------------------------------------
  qsr_clkdiv #(.DIV_W(DIV_W)) u_div (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (state_r != qsr_pkg::QSR_IDLE),
    .div     (serial_clock_divide_factor),
    .rise_tk (rise_tk),
    .fall_tk (fall_tk)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      dq_s1_r <= dq_i;
      dq_s2_r <= dq_s1_r;
    end
  end

  assign accept = (state_r == qsr_pkg::QSR_IDLE) && mm_req;
  assign mm_ack = accept;
  assign busy   = (state_r != qsr_pkg::QSR_IDLE);
  assign smp    = (state_r == qsr_pkg::QSR_DATA) && fall_tk;

  // msb first: earlier bits move up, the lane group with d3/d1 on top
  always_comb begin
    col_nxt = col_r + bits_per_edge(mode_r);
    if (mode_r == qsr_pkg::LANE_SINGLE) begin
      sh_nxt = {sh_r[qsr_pkg::WORD_MAX-2:0], dq_s2_r[1]};
    end else if (mode_r == qsr_pkg::LANE_DUAL) begin
      sh_nxt = {sh_r[qsr_pkg::WORD_MAX-3:0], dq_s2_r[1:0]};
    end else begin
      sh_nxt = {sh_r[qsr_pkg::WORD_MAX-5:0], dq_s2_r};
    end
    wdone = smp && (col_nxt > {1'b0, len_r});
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r   <= qsr_pkg::QSR_IDLE;
      per_r     <= '0;
      cmd_cnt_r <= '0;
      words_r   <= '0;
    end else begin
      case (state_r)
        qsr_pkg::QSR_IDLE: begin
          per_r     <= '0;
          cmd_cnt_r <= '0;
          words_r   <= word_cnt;
          if (accept && select_to_clock_delay_field == 2'h0) begin
            state_r <= qsr_pkg::QSR_CMD;
          end else if (accept) begin
            state_r <= qsr_pkg::QSR_SEL;
          end
        end
        qsr_pkg::QSR_SEL: begin
          // clock held low for the programmed number of whole periods
          if (fall_tk && per_r == select_to_clock_delay_field - 2'h1) begin
            state_r <= qsr_pkg::QSR_CMD;
          end else if (fall_tk) begin
            per_r <= per_r + 2'h1;
          end
        end
        qsr_pkg::QSR_CMD: begin
          if (fall_tk && cmd_cnt_r == qsr_pkg::CMD_LAST) begin
            state_r <= qsr_pkg::QSR_DATA;
          end else if (fall_tk) begin
            cmd_cnt_r <= cmd_cnt_r + 5'h1;
          end
        end
        qsr_pkg::QSR_DATA: begin
          per_r <= '0;
          if (wdone && words_r == '0) begin
            state_r <= qsr_pkg::QSR_TAIL;
          end else if (wdone) begin
            words_r <= words_r - qsr_pkg::CNT_W'(1);
          end
        end
        qsr_pkg::QSR_TAIL: begin
          if (fall_tk && per_r == qsr_pkg::TAIL_PERIODS - 2'h1) begin
            state_r <= qsr_pkg::QSR_IDLE;
          end else if (fall_tk) begin
            per_r <= per_r + 2'h1;
          end
        end
        default: state_r <= qsr_pkg::QSR_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pins: clock, select and command line
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclk <= 1'b0;
      cs_n <= 1'b1;
    end else begin
      // the clock only toggles while command or data bits move
      if (state_r != qsr_pkg::QSR_CMD && state_r != qsr_pkg::QSR_DATA) begin
        sclk <= 1'b0;
      end else if (rise_tk) begin
        sclk <= 1'b1;
      end else if (fall_tk) begin
        sclk <= 1'b0;
      end
      if (accept) begin
        cs_n <= 1'b0;
      end else if (state_r == qsr_pkg::QSR_TAIL && fall_tk && per_r == qsr_pkg::TAIL_PERIODS - 2'h1) begin
        cs_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_sh_r <= '0;
      dq_o     <= '0;
      dq_oe    <= '0;
    end else begin
      dq_o[3:1]  <= '0;
      dq_oe[3:1] <= '0;
      if (accept) begin
        cmd_sh_r <= {cmd_opcode, mm_addr};
      end
      // first bit goes out as the clocked periods begin, a full period before the first fall
      if ((accept && select_to_clock_delay_field == 2'h0) ||
          (state_r == qsr_pkg::QSR_SEL && fall_tk && per_r == select_to_clock_delay_field - 2'h1)) begin
        dq_o[0]  <= accept ? cmd_opcode[7] : cmd_sh_r[31];
        dq_oe[0] <= 1'b1;
      end else if (state_r == qsr_pkg::QSR_CMD && fall_tk && cmd_cnt_r == qsr_pkg::CMD_LAST) begin
        dq_o[0]  <= 1'b0;
        dq_oe[0] <= 1'b0;
      end else if (state_r == qsr_pkg::QSR_CMD && fall_tk) begin
        dq_o[0]  <= cmd_sh_r[30];
        cmd_sh_r <= {cmd_sh_r[30:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // word assembly and completion events
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_r <= qsr_pkg::LANE_SINGLE;
      len_r  <= '0;
      col_r  <= '0;
      sh_r   <= '0;
    end else if (accept) begin
      mode_r <= lane_mode;
      len_r  <= word_len;
      col_r  <= '0;
      sh_r   <= '0;
    end else if (wdone) begin
      col_r  <= '0;
      sh_r   <= '0;
    end else if (smp) begin
      col_r  <= col_nxt;
      sh_r   <= sh_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      word_data  <= '0;
      word_valid <= 1'b0;
      word_irq   <= 1'b0;
      frame_done <= 1'b0;
      frame_irq  <= 1'b0;
    end else begin
      word_valid <= wdone;
      word_irq   <= wdone && word_irq_en;
      frame_done <= wdone && words_r == '0;
      frame_irq  <= wdone && words_r == '0 && frame_irq_en;
      if (wdone) begin
        word_data <= sh_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  idle_pins_a: assert property (state_r == qsr_pkg::QSR_IDLE && !$past(accept) |-> !sclk && dq_oe == 4'h0)
    else $error("clock or data driven while idle");
  sel_clock_a: assert property (state_r == qsr_pkg::QSR_SEL |-> !cs_n && !sclk)
    else $error("clock moved during select delay");
  sel_len_a: assert property (state_r == qsr_pkg::QSR_SEL |-> per_r < select_to_clock_delay_field)
    else $error("select delay overran");
  cmd_launch_a: assert property ($changed(dq_o[0]) && state_r == qsr_pkg::QSR_CMD && $past(state_r) == qsr_pkg::QSR_CMD
                                 |-> $past(fall_tk) && !sclk)
    else $error("command bit launched off a falling edge");
  in_lanes_a: assert property (dq_oe[3:1] == 3'h0)
    else $error("input lane driven");
  word_len_a: assert property (word_valid |-> $past(col_nxt) > {1'b0, $past(len_r)} && col_r == 8'h00)
    else $error("word ended at wrong length");
  word_irq_a: assert property (word_irq |-> word_valid ##1 !word_irq)
    else $error("word interrupt without word");
  frame_cs_a: assert property (frame_done |-> !cs_n && state_r == qsr_pkg::QSR_TAIL)
    else $error("select dropped before frame end");
  tail_a: assert property ($rose(cs_n) |-> $past(state_r) == qsr_pkg::QSR_TAIL && $past(per_r) == 2'h1)
    else $error("select released early");
  sample_a: assert property ($changed(col_r) && col_r != 8'h00 |-> $past(fall_tk) && $past(sclk))
    else $error("sample off the falling edge");

  frame_c: cover property (frame_done ##[1:200] $rose(cs_n));
  quad_c: cover property (word_valid && mode_r == qsr_pkg::LANE_QUAD);
  delay_c: cover property (state_r == qsr_pkg::QSR_SEL && select_to_clock_delay_field == 2'h3 ##1
                           state_r == qsr_pkg::QSR_CMD);
endmodule : qsr_ctrl // qsr_ctrl

`default_nettype wire

// ---- qsr_flash_model.sv ----
// flash-side model: takes 32 command bits on sclk rises, then serves one nibble per sclk fall
// assumes clock mode 0 and that the bench resolves dq0 from the controller's enable
`default_nettype none

module qsr_flash_model (
  input  wire logic        clk_sys,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        dq0,
  output logic [3:0]       q,
  output logic [31:0]      cmd_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  int   rises = 0;
  int   k     = 0;
  logic sk_q  = 1'b0;

  // one process owns every model variable; an sclk change is told from a clk_sys edge by the last sclk seen
  always @(posedge clk_sys or sclk or posedge cs_n) begin
    if (sclk !== sk_q && sclk === 1'b1 && cs_n === 1'b0 && rises < 32) begin
      cmd_rx <= {cmd_rx[30:0], dq0};
      rises  <= rises + 1;
    end else if (sclk !== sk_q && sclk === 1'b0 && cs_n === 1'b0 && rises >= 32) begin
      // data launched on falls, so the controller must take it on the next fall
      q <= #1 cmd_rx[3:0] + 4'(k * 7);
      k <= k + 1;
    end else if (sclk === sk_q && cs_n === 1'b1) begin
      // a deselected flash floats; flipping every cycle keeps a stale value from passing as data
      q <= (q == 4'h5) ? 4'ha : 4'h5;
    end
    if (cs_n === 1'b1) begin
      rises <= 0;
      k     <= 0;
    end
    sk_q = sclk;
  end
endmodule // qsr_flash_model

`default_nettype wire

// ---- tb_qsr_ctrl.sv ----
// bench for the quad read controller: a table of frame shapes, then reset and held-request cases
// assumes the flash model answers from the address low nibble and nothing else drives dq
`default_nettype none

module tb_qsr_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] ln; logic [6:0] len; logic [11:0] cnt; logic [1:0] dly; logic [7:0] dv;
                  logic we; logic fe; int per; int hi;} qsr_row_t;
  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  logic         mm_req = 1'b0;
  logic [23:0]  mm_addr = 24'h0;
  logic [7:0]   cmd_opcode = 8'h0;
  logic [1:0]   lane_mode = 2'h0;
  logic [6:0]   word_len = 7'h0;
  logic [11:0]  word_cnt = 12'h0;
  logic [1:0]   select_to_clock_delay_field = 2'h0;
  logic [7:0]   serial_clock_divide_factor = 8'h3;
  logic         word_irq_en = 1'b0;
  logic         frame_irq_en = 1'b0;
  logic         mm_ack, busy, word_valid, frame_done, word_irq, frame_irq, sclk, cs_n;
  logic [127:0] word_data;
  logic [3:0]   dq_o, dq_oe, fq;
  logic [31:0]  cmd_rx;
  wire  [3:0]   dq_i = {fq[3:1], dq_oe[0] ? dq_o[0] : fq[0]};
  int           fails, total_checks, acks, wv, wi, fi, fd, csr, pin_bad, k, cyc;
  int           t_cl, t_ff, t_lf, t_ch, t_sr, t_sf, hi, lo, ak0, wv0, wi0, fi0, fd0, cs0;
  logic         cs_q = 1'b1;
  logic         sk_q = 1'b0;
  logic         first = 1'b0;
  qsr_row_t     rows [6] = '{
    '{qsr_pkg::LANE_SINGLE, 7'h00, 12'h000, 2'h0, 8'h03, 1'b1, 1'b1, 4, 2},
    '{qsr_pkg::LANE_DUAL,   7'h06, 12'h002, 2'h1, 8'h03, 1'b1, 1'b0, 4, 2},
    '{qsr_pkg::LANE_QUAD,   7'h7f, 12'h001, 2'h3, 8'h05, 1'b0, 1'b1, 6, 3},
    '{2'h3,                 7'h09, 12'h000, 2'h2, 8'h04, 1'b1, 1'b1, 5, 2},
    '{qsr_pkg::LANE_SINGLE, 7'h0f, 12'h003, 2'h0, 8'h07, 1'b0, 1'b0, 8, 4},
    '{qsr_pkg::LANE_SINGLE, 7'h00, 12'hfff, 2'h0, 8'h03, 1'b1, 1'b0, 4, 2}};

  qsr_ctrl #(.DIV_W(8)) u_qsr_ctrl (.clk_sys, .rst, .mm_req, .mm_addr, .mm_ack, .cmd_opcode, .lane_mode,
    .word_len, .word_cnt, .select_to_clock_delay_field, .serial_clock_divide_factor, .word_irq_en,
    .frame_irq_en, .busy, .word_data, .word_valid, .frame_done, .word_irq, .frame_irq, .sclk, .cs_n,
    .dq_i, .dq_o, .dq_oe);
  qsr_flash_model u_qsr_flash_model (.clk_sys, .sclk, .cs_n, .dq0(dq_i[0]), .q(fq), .cmd_rx);

  always #20 clk_sys = ~clk_sys;

  task automatic results();
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_w(input logic [127:0] got, input logic [127:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp, input int tol);
    total_checks++;
    if (got < exp - tol || got > exp + tol) begin
      fails++;
      $display("CHECK FAILED %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // pin monitor: edges in system cycles, words against the nibble stream
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    int n, f;
    logic [3:0] nb;
    logic [127:0] e;
    cyc++;
    if (!rst && mm_ack === 1'b1) begin
      acks++;
      k = 0;
    end
    if (!rst && ((cs_n === 1'b1 && sclk !== 1'b0) || dq_oe[3:1] !== 3'h0)) pin_bad++;
    if (cs_n === 1'b0 && cs_q === 1'b1) begin
      t_cl = cyc;
      first = 1'b1;
    end
    if (cs_n === 1'b1 && cs_q === 1'b0) begin
      t_ch = cyc;
      csr++;
    end
    if (sclk === 1'b1 && sk_q === 1'b0) begin
      lo = cyc - t_sf;
      t_sr = cyc;
    end
    if (sclk === 1'b0 && sk_q === 1'b1) begin
      // lead of select over the first fall, kept per frame so a back-to-back select cannot spoil it
      if (first) t_ff = cyc - t_cl;
      first = 1'b0;
      hi = cyc - t_sr;
      t_sf = cyc;
      t_lf = cyc;
    end
    cs_q = cs_n;
    sk_q = sclk;
    wi += (word_irq === 1'b1);
    fi += (frame_irq === 1'b1);
    fd += (frame_done === 1'b1);
    if (word_valid === 1'b1) begin
      wv++;
      n = (lane_mode == 2'h0) ? 1 : (lane_mode == 2'h1) ? 2 : 4;
      f = (word_len + n) / n;
      e = '0;
      for (int i = 0; i < f; i++) begin
        nb = mm_addr[3:0] + 4'(k * 7);
        e = (e << n) | 128'((n == 1) ? nb[1] : (n == 2) ? nb[1:0] : nb);
        k++;
      end
      chk_w(word_data, e);
    end
  end

  // ----------------------------------------------------------------
  // frame tasks and scenarios
  // ----------------------------------------------------------------
  task automatic wt(input int md);
    int i;
    for (i = 0; i < 20000; i++) begin
      @(posedge clk_sys);
      if (md == 0 && mm_ack === 1'b1) break;
      if (md == 1 && frame_done === 1'b1) break;
      if (md == 2 && busy === 1'b0) break;
    end
    if (i == 20000) begin
      fails++;
      results();
    end
  endtask

  task automatic mark();
    ak0 = acks;
    wv0 = wv;
    wi0 = wi;
    fi0 = fi;
    fd0 = fd;
    cs0 = csr;
  endtask

  task automatic start(input qsr_row_t r, input logic [23:0] a, input logic hold);
    @(posedge clk_sys);
    #1;
    mark();
    lane_mode = r.ln;
    word_len = r.len;
    word_cnt = r.cnt;
    select_to_clock_delay_field = r.dly;
    serial_clock_divide_factor = r.dv;
    word_irq_en = r.we;
    frame_irq_en = r.fe;
    mm_addr = a;
    cmd_opcode = a[7:0] ^ 8'h5a;
    mm_req = 1'b1;
    wt(0);
    #1;
    mm_req = hold;
  endtask

  task automatic fin(input qsr_row_t r, input logic hold);
    wt(1);
    if (hold) chk_n(acks - ak0, 1, 0);
    wt(2);
    @(posedge clk_sys);
    #1;
    chk_n(wv - wv0, r.cnt + 1, 0);
    chk_n(csr - cs0, 1, 0);
    chk_n(fd - fd0, 1, 0);
    chk_n(wi - wi0, r.we ? r.cnt + 1 : 0, 0);
    chk_n(fi - fi0, r.fe, 0);
    chk_w({96'h0, cmd_rx}, {96'h0, cmd_opcode, mm_addr});
    chk_n(t_ff, (r.dly + 1) * r.per, 1);
    chk_n(t_ch - t_lf, 2 * r.per, 1);
    chk_n(hi, r.hi, 0);
    chk_n(lo, r.per - r.hi, 0);
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    #1;
    chk_w({120'h0, sclk, cs_n, busy, word_valid, dq_oe}, {120'h0, 8'h40});
    rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      start(rows[i], 24'h0a1230 + 24'(i * 5), 1'b0);
      fin(rows[i], 1'b0);
    end
    // abort in mid-command; the next request must run clean
    start(rows[0], 24'h000007, 1'b0);
    repeat (30) @(posedge clk_sys);
    #1;
    rst = 1'b1;
    // held across two edges so history-based checks restart from reset values
    repeat (2) @(posedge clk_sys);
    #1;
    chk_w({120'h0, sclk, cs_n, busy, word_valid, dq_oe}, {120'h0, 8'h40});
    rst = 1'b0;
    // request held high: refused while busy, taken again right after idle
    start(rows[1], 24'h00000b, 1'b1);
    fin(rows[1], 1'b1);
    mm_req = 1'b0;
    mark();
    fin(rows[1], 1'b0);
    chk_n(pin_bad, 0, 0);
    results();
  end
endmodule // tb_qsr_ctrl

`default_nettype wire
